// file: hdl/fpa_defines.svh
// Constants of the floating-point absolute, add and compare slice
`ifndef FPA_DEFINES_SVH
`define FPA_DEFINES_SVH
`define FPA_ADDR_W      5
`define FPA_REG_LAST    5'h0f
`define FPA_STATUS_ADDR 5'h10
`define FPA_STATUS_RST  32'h0000_0000
`define FPA_FLAG_LSB    0
`define FPA_EN_LSB      5
`define FPA_CAUSE_LSB   10
`define FPA_FLUSH_BIT   18
`define FPA_PREC_BIT    19
`define FPA_B_I         0
`define FPA_B_U         1
`define FPA_B_O         2
`define FPA_B_Z         3
`define FPA_B_V         4
`define FPA_B_E         5
`define FPA_SIGN_CLR    32'h7fff_ffff
`define FPA_QNAN_S      32'h7fbf_ffff
`define FPA_QNAN_D_HI   32'h7ff7_ffff
`define FPA_QNAN_D_LO   32'hffff_ffff
`define FPA_INF_S       31'h7f80_0000
`define FPA_INF_D       31'h7ff0_0000
`define FPA_EMAX_S      11'h0ff
`define FPA_EMAX_D      11'h7ff
`define FPA_OVF_S       11'h0fe
`define FPA_OVF_D       11'h7fe
`define FPA_UNF_S       11'h018
`define FPA_UNF_D       11'h035
`define FPA_OP_PREFIX   4'hf
`define FPA_OP_ABS      8'h5d
`define FPA_OP_ADD      4'h0
`define FPA_OP_CEQ      4'h4
`define FPA_OP_CGT      4'h5
`endif

// file: hdl/fpa_pkg.sv
// Types of the floating-point absolute, add and compare slice
package fpa_pkg;
  typedef enum logic [2:0] {
    cls_norm,
    cls_pzero,
    cls_nzero,
    cls_denorm,
    cls_pinf,
    cls_ninf,
    cls_qnan,
    cls_snan
  } fpa_class_t;
endpackage : fpa_pkg

// file: hdl/fpa_unit.sv
// Floating-point absolute value, add and compare execution slice
`timescale 1ns/1ps
`include "fpa_defines.svh"
//////////////////////////////////////////////////////////////////////
// Overview of operation
// [RQ1] Absolute value clears bit 31, any precision
// [RQ2] Absolute value leaves cause and flags alone
// [RQ3] Add single or double pairs by precision
// [RQ4] Inexact enable makes every add trap
// [RQ5] On trap record cause, keep destination; I, O and U enable traps set no cause bit of their own
// [RQ6] Add checks signalling, quiet NaN, then denormal
// [RQ7] Flush mode treats denormals as signed zero
// [RQ8] Invalid sets cause, writes default NaN or traps
// [RQ9] Opposite infinities invalid, else infinity sign
// [RQ10] Zero sums signed, normal plus zero kept
// [RQ11] Overflow trap on same sign, threshold exponent
// [RQ12] Underflow trap on differing signs, small exponents
// [RQ13] Compare equal sets condition bit, quiet NaN 0
// [RQ14] Compare greater: destination above source
// [RQ15] Double compare equal decodes and writes bit
// [RQ16] Greater is invalid on any NaN
// [RQ17] Compare invalid sets cause, clears bit or traps
// [RQ18] Signed zeros equal, infinities order extremes
// [RQ19] Equal is invalid only for signalling NaN
// [RQ20] Double uses even/odd pairs, cause cleared first
//////////////////////////////////////////////////////////////////////
module fpa_unit (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [4:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_op_valid,
  input  wire logic [15:0] i_opcode,
  output logic             o_done,
  output logic             o_trap,
  output logic             o_t_valid,
  output logic             o_t_bit,
  output logic             o_datapath_req
);

  //////////////////////////////////////////////////////////////////////
  // Operand decoding helpers
  function automatic logic [10:0] fpa_exp(input logic [63:0] v,
                                          input logic        dbl);
    fpa_exp = dbl ? v[62:52] : {3'h0, v[62:55]};
  endfunction : fpa_exp

  function automatic fpa_pkg::fpa_class_t fpa_classify(
    input logic [63:0] v,
    input logic        dbl,
    input logic        flush
  );
    logic [10:0] e;
    logic        mz;
    logic        mq;
    e  = fpa_exp(v, dbl);
    mz = dbl ? (v[51:0] == 52'h0) : (v[54:32] == 23'h0);
    mq = dbl ? v[51] : v[54];
    if (e == 11'h0) begin
      if (mz || flush) begin // [RQ7]
        fpa_classify = v[63] ? fpa_pkg::cls_nzero : fpa_pkg::cls_pzero;
      end else begin
        fpa_classify = fpa_pkg::cls_denorm;
      end
    end else if (e != (dbl ? `FPA_EMAX_D : `FPA_EMAX_S)) begin
      fpa_classify = fpa_pkg::cls_norm;
    end else if (mz) begin
      fpa_classify = v[63] ? fpa_pkg::cls_ninf : fpa_pkg::cls_pinf;
    end else if (mq) begin
      fpa_classify = fpa_pkg::cls_snan;
    end else begin
      fpa_classify = fpa_pkg::cls_qnan;
    end
  endfunction : fpa_classify

  function automatic logic fpa_is_zero(input fpa_pkg::fpa_class_t c);
    fpa_is_zero = (c == fpa_pkg::cls_pzero) ||
                  (c == fpa_pkg::cls_nzero);
  endfunction : fpa_is_zero

  function automatic logic [62:0] fpa_mag(input logic [63:0]         v,
                                          input fpa_pkg::fpa_class_t c);
    fpa_mag = fpa_is_zero(c) ? 63'h0 : v[62:0];
  endfunction : fpa_mag

  //////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] regs [0:15];
  logic [31:0] status, rdata;
  logic        t_bit, trap, done, t_valid, dp_req;

  logic [31:0] next_status, next_rdata, next_hi, next_lo;
  logic        next_t_bit, next_trap, next_done, next_t_valid;
  logic        next_dp_req, next_bus_we, next_hi_we, next_lo_we;
  logic [3:0]  next_hi_idx, next_lo_idx;

  //////////////////////////////////////////////////////////////////////
  // Decode and operand fetch
  logic                precision_select, denormal_flush;
  logic [4:0]          en;
  logic                is_fp, dbl_ok, do_abs, do_add, do_ceq, do_cgt;
  logic [3:0]          n_idx, m_idx;
  logic [63:0]         op_n, op_m;
  fpa_pkg::fpa_class_t cn, cm;
  logic [10:0]         e_n, e_m;
  logic [62:0]         mag_n, mag_m;
  logic                eq, gt, any_snan, any_qnan;

  assign precision_select = status[`FPA_PREC_BIT];
  assign denormal_flush   = status[`FPA_FLUSH_BIT];
  assign en     = status[`FPA_EN_LSB +: 5];
  assign is_fp  = i_op_valid && (i_opcode[15:12] == `FPA_OP_PREFIX);
  assign dbl_ok = !precision_select || (!i_opcode[8] && !i_opcode[4]);
  assign do_abs = is_fp && (i_opcode[7:0] == `FPA_OP_ABS); // [RQ2]
  assign do_add = is_fp && dbl_ok &&
                  (i_opcode[3:0] == `FPA_OP_ADD); // [RQ3]
  assign do_ceq = is_fp && dbl_ok &&
                  (i_opcode[3:0] == `FPA_OP_CEQ); // [RQ15]
  assign do_cgt = is_fp && dbl_ok &&
                  (i_opcode[3:0] == `FPA_OP_CGT); // [RQ14]
  // Even register carries the upper word of a pair
  assign n_idx  = precision_select ? {i_opcode[11:9], 1'b0} :
                  i_opcode[11:8]; // [RQ20]
  assign m_idx  = precision_select ? {i_opcode[7:5], 1'b0} : i_opcode[7:4];
  assign op_n   = {regs[n_idx], regs[n_idx | 4'h1] & {32{precision_select}}};
  assign op_m   = {regs[m_idx], regs[m_idx | 4'h1] & {32{precision_select}}};
  assign cn     = fpa_classify(op_n, precision_select, denormal_flush);
  assign cm     = fpa_classify(op_m, precision_select, denormal_flush);
  assign e_n    = fpa_exp(op_n, precision_select);
  assign e_m    = fpa_exp(op_m, precision_select);
  assign mag_n  = fpa_mag(op_n, cn);
  assign mag_m  = fpa_mag(op_m, cm);
  assign any_snan = (cn == fpa_pkg::cls_snan) ||
                    (cm == fpa_pkg::cls_snan);
  assign any_qnan = (cn == fpa_pkg::cls_qnan) ||
                    (cm == fpa_pkg::cls_qnan);
  // Zeros equal whatever their sign
  assign eq = (mag_n == mag_m) &&
              ((op_n[63] == op_m[63]) || (mag_n == 63'h0)); // [RQ18]
  assign gt = !eq && ((op_n[63] != op_m[63]) ? !op_n[63] :
              (op_n[63] ? (mag_n < mag_m) : (mag_n > mag_m)));

  //////////////////////////////////////////////////////////////////////
  // Execution and register file next values
  logic [5:0]  cause;
  logic        trap_req, wr_req;
  logic [63:0] wval, qnan_val, pinf_val, ninf_val;

  assign qnan_val = precision_select ? {`FPA_QNAN_D_HI, `FPA_QNAN_D_LO} :
                                       {`FPA_QNAN_S, 32'h0};
  assign pinf_val = {1'b0, precision_select ? `FPA_INF_D : `FPA_INF_S, 32'h0};
  assign ninf_val = {1'b1, precision_select ? `FPA_INF_D : `FPA_INF_S, 32'h0};

  always_comb begin
    next_status  = status;
    next_rdata   = 32'h0;
    next_t_bit   = t_bit;
    next_trap    = 1'b0;
    next_done    = 1'b0;
    next_t_valid = 1'b0;
    next_dp_req  = 1'b0;
    next_bus_we  = i_wr && (i_addr <= `FPA_REG_LAST);
    next_hi_we   = 1'b0;
    next_lo_we   = 1'b0;
    next_hi_idx  = n_idx;
    next_lo_idx  = n_idx | 4'h1;
    cause        = 6'h0;
    trap_req     = 1'b0;
    wr_req       = 1'b0;
    wval         = 64'h0;
    if (i_rd) begin
      if (i_addr <= `FPA_REG_LAST) begin
        next_rdata = regs[i_addr[3:0]];
      end else if (i_addr == `FPA_STATUS_ADDR) begin
        next_rdata = status;
      end
    end
    if (i_wr && (i_addr == `FPA_STATUS_ADDR)) begin
      next_status = i_wdata;
    end
    if (do_abs) begin
      next_hi_idx = i_opcode[11:8];
      wval        = {regs[i_opcode[11:8]] & `FPA_SIGN_CLR, 32'h0}; // [RQ1]
      next_hi_we  = 1'b1;
    end
    if (do_add) begin
      if (any_snan) begin // [RQ6]
        cause[`FPA_B_V] = 1'b1; // [RQ8]
        trap_req        = en[`FPA_B_V];
        wr_req          = 1'b1;
        wval            = qnan_val;
      end else if (any_qnan) begin
        wr_req = 1'b1;
        wval   = qnan_val;
      end else if ((cn == fpa_pkg::cls_denorm) ||
                   (cm == fpa_pkg::cls_denorm)) begin
        cause[`FPA_B_E] = 1'b1;
        trap_req        = 1'b1;
      end else begin
        case (cm)
          fpa_pkg::cls_norm: begin
            if (cn == fpa_pkg::cls_norm) begin
              next_dp_req = 1'b1;
            end else if (fpa_is_zero(cn)) begin
              wr_req = 1'b1; // [RQ10]
              wval   = op_m;
            end
          end
          fpa_pkg::cls_pzero: begin
            if (cn == fpa_pkg::cls_nzero) begin
              wr_req = 1'b1; // [RQ10]
              wval   = 64'h0;
            end
          end
          fpa_pkg::cls_pinf: begin
            if (cn == fpa_pkg::cls_ninf) begin
              cause[`FPA_B_V] = 1'b1; // [RQ9]
              trap_req        = en[`FPA_B_V];
              wr_req          = 1'b1;
              wval            = qnan_val;
            end else begin
              wr_req = 1'b1;
              wval   = pinf_val;
            end
          end
          fpa_pkg::cls_ninf: begin
            if (cn == fpa_pkg::cls_pinf) begin
              cause[`FPA_B_V] = 1'b1; // [RQ9]
              trap_req        = en[`FPA_B_V];
              wr_req          = 1'b1;
              wval            = qnan_val;
            end else begin
              wr_req = 1'b1;
              wval   = ninf_val;
            end
          end
          default: wr_req = 1'b0;
        endcase
      end
      if (en[`FPA_B_I]) begin
        trap_req = 1'b1; // [RQ4]
      end
      if (en[`FPA_B_O] && (op_n[63] == op_m[63]) &&
          ((e_n == (precision_select ? `FPA_OVF_D : `FPA_OVF_S)) ||
           (e_m == (precision_select ? `FPA_OVF_D : `FPA_OVF_S)))) begin
        trap_req = 1'b1; // [RQ11]
      end
      if (en[`FPA_B_U] && (op_n[63] != op_m[63]) &&
          (e_n <= (precision_select ? `FPA_UNF_D : `FPA_UNF_S)) &&
          (e_m <= (precision_select ? `FPA_UNF_D : `FPA_UNF_S))) begin
        trap_req = 1'b1; // [RQ12]
      end
      next_hi_we  = wr_req && !trap_req; // [RQ5]
      next_lo_we  = wr_req && !trap_req && precision_select;
      next_dp_req = next_dp_req && !trap_req;
    end
    if (do_ceq) begin
      if (any_snan) begin // [RQ19]
        cause[`FPA_B_V] = 1'b1; // [RQ17]
        trap_req        = en[`FPA_B_V];
        next_t_bit      = 1'b0;
      end else begin
        next_t_bit = !any_qnan && eq; // [RQ13]
      end
    end
    if (do_cgt) begin
      if (any_snan || any_qnan) begin // [RQ16]
        cause[`FPA_B_V] = 1'b1; // [RQ17]
        trap_req        = en[`FPA_B_V];
        next_t_bit      = 1'b0;
      end else begin
        next_t_bit = gt; // [RQ14]
      end
    end
    if (do_ceq || do_cgt) begin
      next_t_valid = !trap_req;
      if (trap_req) begin
        next_t_bit = t_bit;
      end
    end
    if (do_add || do_ceq || do_cgt) begin
      // Fresh cause each operation, flags only accumulate
      next_status[`FPA_CAUSE_LSB +: 6] = cause; // [RQ20]
      next_status[`FPA_FLAG_LSB +: 5]  =
        next_status[`FPA_FLAG_LSB +: 5] | cause[4:0]; // [RQ5]
    end
    next_trap = trap_req;
    next_done = do_abs || do_add || do_ceq || do_cgt;
    next_hi   = wval[63:32];
    next_lo   = wval[31:0];
  end

  //////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 32'h0;
      end
      status  <= `FPA_STATUS_RST;
      rdata   <= 32'h0;
      t_bit   <= 1'b0;
      trap    <= 1'b0;
      done    <= 1'b0;
      t_valid <= 1'b0;
      dp_req  <= 1'b0;
    end else begin
      if (next_bus_we) begin
        regs[i_addr[3:0]] <= i_wdata;
      end
      // Operation writes land after the bus write and win
      if (next_hi_we) begin
        regs[next_hi_idx] <= next_hi;
      end
      if (next_lo_we) begin
        regs[next_lo_idx] <= next_lo;
      end
      status  <= next_status;
      rdata   <= next_rdata;
      t_bit   <= next_t_bit;
      trap    <= next_trap;
      done    <= next_done;
      t_valid <= next_t_valid;
      dp_req  <= next_dp_req;
    end
  end

  assign o_rdata        = rdata;
  assign o_t_bit        = t_bit;
  assign o_trap         = trap;
  assign o_done         = done;
  assign o_t_valid      = t_valid;
  assign o_datapath_req = dp_req;
endmodule : fpa_unit

// file: tb/fpa_chk.sv
// Port checker of the fp absolute, add and compare slice
`timescale 1ns/1ps
module fpa_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [4:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_op_valid,
  input wire logic [15:0] i_opcode,
  input wire logic        o_done,
  input wire logic        o_trap,
  input wire logic        o_t_valid,
  input wire logic        o_t_bit,
  input wire logic        o_datapath_req
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire logic is_op = i_op_valid && i_opcode[15:12] == 4'hf;
  //////////////////////////////////////////////////////////////////////
  done_cause_a: assert property (o_done |-> $past(is_op))
    else $error("done without an issued op");
  foreign_quiet_a: assert property (
    i_op_valid && i_opcode[15:12] != 4'hf |=> !o_done)
    else $error("done after a foreign opcode");
  trap_done_a: assert property (
    o_trap |-> o_done && !o_datapath_req)
    else $error("trap without done or with datapath request");
  tvalid_done_a: assert property (
    o_t_valid |-> o_done && !o_trap)
    else $error("condition written beside a trap");
  tbit_hold_a: assert property (
    !o_t_valid && !$past(i_sys_rst) |-> $stable(o_t_bit))
    else $error("condition bit moved without a compare");
  abs_quiet_a: assert property (
    is_op && i_opcode[7:0] == 8'h5d |=>
    o_done && !o_trap && !o_t_valid && !o_datapath_req)
    else $error("absolute value not quiet");
  add_no_t_a: assert property (
    is_op && i_opcode[3:0] == 4'h0 |=> !o_t_valid)
    else $error("add wrote the condition bit");
  cmp_no_dreq_a: assert property (
    is_op && i_opcode[3:1] == 3'b010 |=> !o_datapath_req)
    else $error("compare asked for the datapath");
endmodule : fpa_chk

bind fpa_unit fpa_chk fpa_chk_inst (
  .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_op_valid, .i_opcode, .o_done, .o_trap, .o_t_valid, .o_t_bit,
  .o_datapath_req
);

// file: tb/fpa_cpu_model.sv
// Issue side of the cpu decoder in front of the slice
`timescale 1ns/1ps
module fpa_cpu_model (
  input  wire logic        i_clk,
  output logic             o_op_valid,
  output logic      [15:0] o_opcode
);
  initial begin
    o_op_valid = 1'b0;
    o_opcode   = 16'h0;
  end
  // One-cycle issue, opcode scrambled once released
  task automatic issue(input logic [15:0] op);
    @(posedge i_clk);
    o_op_valid <= 1'b1;
    o_opcode   <= op;
    @(posedge i_clk);
    o_op_valid <= 1'b0;
    o_opcode   <= ~op;
  endtask : issue
endmodule : fpa_cpu_model

// file: tb/tb.sv
// Self-checking bench of the fp slice
`timescale 1ns/1ps
`include "fpa_defines.svh"
module tb;
  localparam logic [4:0]  ST = `FPA_STATUS_ADDR;
  localparam logic [31:0] PREC_SEL  = 32'h0008_0000;
  localparam logic [31:0] FLUSH_SEL = 32'h0004_0000;
  logic        i_clk     = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [4:0]  i_addr    = 5'h0;
  logic [31:0] i_wdata   = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [31:0] o_rdata;
  logic        i_op_valid;
  logic [15:0] i_opcode;
  logic        o_done;
  logic        o_trap;
  logic        o_t_valid;
  logic        o_t_bit;
  logic        o_datapath_req;
  int          errors     = 0;
  int          n_compared = 0;

  always #2.5 i_clk = ~i_clk;

  fpa_unit fpa_unit_inst (
    .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_op_valid, .i_opcode, .o_done, .o_trap, .o_t_valid, .o_t_bit,
    .o_datapath_req
  );
  fpa_cpu_model fpa_cpu_model_inst (
    .i_clk,
    .o_op_valid (i_op_valid),
    .o_opcode   (i_opcode)
  );
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", w, e, s);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk($sformatf("reg %0d", a), o_rdata, e);
  endtask : rdc
  task automatic ld(input logic [31:0] s, input logic [4:0] n,
                    input logic [31:0] vn, input logic [4:0] m,
                    input logic [31:0] vm);
    wr(ST, s);
    wr(n, vn);
    wr(m, vm);
  endtask : ld
  task automatic op(input logic [15:0] c, input logic tr, tv, t);
    fpa_cpu_model_inst.issue(c);
    #1;
    chk("done", {31'h0, o_done}, 32'h1);
    chk("trap", {31'h0, o_trap}, {31'h0, tr});
    chk("t_valid", {31'h0, o_t_valid}, {31'h0, tv});
    if (tv) chk("t_bit", {31'h0, o_t_bit}, {31'h0, t});
  endtask : op
  //////////////////////////////////////////////////////////////////////
  task automatic t_abs;
    logic [31:0] s;
    for (int p = 0; p < 2; p++) begin
      s = (p != 0 ? PREC_SEL : 32'h0) | 32'h400;
      ld(s, 5, 32'hff80_1234, 4, 32'hffff_ffff);
      op(16'hf55d, 0, 0, 0);
      rdc(5, 32'h7f80_1234);
      rdc(4, 32'hffff_ffff);
      rdc(ST, s);
    end
  endtask : t_abs
  task automatic t_add;
    ld(32'h400, 1, 32'h8000_0000, 2, 32'h0);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'h0);
    rdc(ST, 32'h0);
    ld(32'h0, 1, 32'h8000_0000, 2, 32'h8000_0000);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'h8000_0000);
    ld(32'h0, 1, 32'h0, 2, 32'h3f80_0000);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'h3f80_0000);
    ld(32'h0, 1, 32'hff80_0000, 2, 32'h7f80_0000);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'h7fbf_ffff);
    rdc(ST, 32'h4010);
    ld(32'h0, 1, 32'h3f80_0000, 2, 32'hff80_0000);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'hff80_0000);
  endtask : t_add
  task automatic t_exc;
    ld(32'h200, 1, 32'h7f80_0001, 2, 32'h7fc0_0000);
    op(16'hf120, 1, 0, 0);
    rdc(1, 32'h7f80_0001);
    rdc(ST, 32'h4210);
    ld(32'h0, 1, 32'h0000_0001, 2, 32'h7f80_0001);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'h7fbf_ffff);
    ld(32'h0, 1, 32'h0000_0001, 2, 32'h3f80_0000);
    op(16'hf120, 1, 0, 0);
    rdc(1, 32'h0000_0001);
    rdc(ST, 32'h8000);
    ld(FLUSH_SEL, 1, 32'h8000_0001, 2, 32'h3f80_0000);
    op(16'hf120, 0, 0, 0);
    rdc(1, 32'h3f80_0000);
    ld(FLUSH_SEL, 1, 32'h0000_0001, 2, 32'h8000_0000);
    op(16'hf124, 0, 1, 1);
    ld(32'h80, 1, 32'h7f00_0000, 2, 32'h3f80_0000);
    op(16'hf120, 1, 0, 0);
    rdc(1, 32'h7f00_0000);
    ld(32'h80, 1, 32'h7e80_0000, 2, 32'h3f80_0000);
    op(16'hf120, 0, 0, 0);
    chk("dreq", {31'h0, o_datapath_req}, 32'h1);
    ld(32'h40, 1, 32'h0c00_0000, 2, 32'h8080_0000);
    op(16'hf120, 1, 0, 0);
    ld(32'h40, 1, 32'h0c80_0000, 2, 32'h8080_0000);
    op(16'hf120, 0, 0, 0);
    ld(32'h20, 1, 32'h8000_0000, 2, 32'h0);
    op(16'hf120, 1, 0, 0);
    rdc(1, 32'h8000_0000);
  endtask : t_exc
  task automatic t_cmp;
    ld(32'h400, 1, 32'h0, 2, 32'h8000_0000);
    op(16'hf124, 0, 1, 1);
    rdc(ST, 32'h0);
    ld(32'h0, 1, 32'h7f80_0000, 2, 32'h3f80_0000);
    op(16'hf125, 0, 1, 1);
    ld(32'h0, 1, 32'h7f80_0001, 2, 32'h3f80_0000);
    op(16'hf125, 0, 1, 0);
    rdc(ST, 32'h4010);
    op(16'hf124, 0, 1, 0);
    rdc(ST, 32'h0010);
    ld(32'h200, 1, 32'h7fc0_0000, 2, 32'h0);
    op(16'hf124, 1, 0, 0);
    ld(32'h0, 1, 32'hff80_0000, 2, 32'h3f80_0000);
    op(16'hf125, 0, 1, 0);
  endtask : t_cmp
  task automatic t_dbl;
    ld(PREC_SEL, 0, 32'h0, 1, 32'h0);
    wr(2, 32'h3ff0_0000);
    wr(3, 32'h1);
    op(16'hf020, 0, 0, 0);
    rdc(0, 32'h3ff0_0000);
    rdc(1, 32'h1);
    op(16'hf004, 0, 1, 1);
    wr(3, 32'h0);
    op(16'hf025, 0, 1, 1);
    op(16'hf024, 0, 1, 0);
    ld(PREC_SEL | 32'h80, 0, 32'h7fe0_0000, 1, 32'h0);
    op(16'hf020, 1, 0, 0);
    ld(PREC_SEL, 0, 32'h7ff8_0000, 1, 32'h0);
    op(16'hf020, 0, 0, 0);
    rdc(0, 32'h7ff7_ffff);
    rdc(1, 32'hffff_ffff);
    rdc(ST, PREC_SEL | 32'h4010);
  endtask : t_dbl
  //////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_abs;
    t_add;
    t_exc;
    t_cmp;
    t_dbl;
    fpa_cpu_model_inst.issue(16'h0120);
    #1;
    chk("done", {31'h0, o_done}, 32'h0);
    wr(5'h11, 32'hffff_ffff);
    rdc(5'h11, 32'h0);
    final_report;
  end
  initial begin
    #20000;
    errors++;
    final_report;
  end
endmodule : tb
